// >>> pkg/atf_defines.vh
`ifndef ATF_DEFINES_VH
`define ATF_DEFINES_VH
// ---------------------------------------------------------------
// ack packet field layout (bit positions within a dword)
// ---------------------------------------------------------------
`define ATF_NUMP_LSB 16
`define ATF_NUMP_MSB 20
`define ATF_SEQ_LSB 21
`define ATF_SEQ_MSB 25
`define ATF_RSV1_LSB 26
`define ATF_RSV1_MSB 30
`define ATF_PF_BIT 31
`define ATF_SID_LSB 0
`define ATF_SID_MSB 15
`define ATF_RSV2_LSB 16
`define ATF_RSV2_MSB 23
`define ATF_SSI_BIT 24
`define ATF_WPA_BIT 25
// mask of the dword 1 bits this block owns (numP, seq, pf)
`define ATF_DW1_MASK 32'h83ff0000
// mask of the dword 2 bits this block owns (stream id, ssi, wpa)
`define ATF_DW2_MASK 32'h0300ffff
// ---------------------------------------------------------------
// apb register byte offsets
// ---------------------------------------------------------------
`define ATF_REG_CTRL 12'h000
`define ATF_REG_STATUS 12'h004
`define ATF_REG_RXF 12'h008
`define ATF_REG_RXS 12'h00c
`define ATF_REG_TXF 12'h010
// ---------------------------------------------------------------
// control register fields and reset value
// ---------------------------------------------------------------
`define ATF_CTRL_SSP 0
`define ATF_CTRL_STREAMS 1
`define ATF_CTRL_SMART 2
`define ATF_CTRL_ISO 3
`define ATF_CTRL_DIRIN 4
`define ATF_CTRL_BURST_LSB 8
`define ATF_CTRL_BURST_MSB 12
`define ATF_CTRL_RST 13'h0000
// ---------------------------------------------------------------
// status register fields
// ---------------------------------------------------------------
`define ATF_ST_INVALID 0
`define ATF_ST_NUMP_OVER 1
`define ATF_ST_TX_SID_ERR 2
`define ATF_ST_WAIT_PING 3
`define ATF_ST_LP_HINT 4
`define ATF_ST_SMART_VALID 5
`endif

// >>> hdl/atf_rx_decode.v
`timescale 1ns/1ns
`default_nettype none
`include "atf_defines.vh"

// ---------------------------------------------------------------
// field extraction and checks for a received ack packet
// ---------------------------------------------------------------
module atf_rx_decode (
  // received dwords
  input wire [31:0] dw1,
  input wire [31:0] dw2,
  // endpoint context
  input wire ssp_mode,
  input wire stream_pipe,
  input wire smart_iso_en,
  input wire iso_out,
  input wire lpf,
  input wire [4:0] max_burst,
  // decoded fields
  output wire [4:0] nump,
  output wire [4:0] seq_num,
  output wire pf,
  output wire [15:0] stream_id,
  output wire ssi,
  output wire wpa,
  // checks
  output wire invalid,
  output wire nump_over,
  output wire smart_valid
);
  // reserved gaps are never looked at, only owned fields are sliced
  assign nump = dw1[`ATF_NUMP_MSB:`ATF_NUMP_LSB];
  assign seq_num = dw1[`ATF_SEQ_MSB:`ATF_SEQ_LSB];
  // pf is reserved outside superspeedplus, so it is masked off
  assign pf = ssp_mode & dw1[`ATF_PF_BIT];
  // stream id only means something on a stream pipe
  assign stream_id = stream_pipe ? dw2[`ATF_SID_MSB:`ATF_SID_LSB] : 16'h0000;
  // deprecated flags read as zero unless legacy smart iso is enabled
  assign ssi = smart_iso_en & dw2[`ATF_SSI_BIT];
  assign wpa = smart_iso_en & dw2[`ATF_WPA_BIT];
  // zero stream id on a stream pipe makes the packet invalid
  assign invalid = stream_pipe & (dw2[`ATF_SID_MSB:`ATF_SID_LSB] == 16'h0000);
  // buffer count above the endpoint's burst size
  assign nump_over = (nump > max_burst);
  // on iso out, the related fields count only with ssi set and lpf clear
  assign smart_valid = iso_out & ssi & ~lpf;
endmodule // atf_rx_decode
`default_nettype wire

// >>> hdl/atf_ack_codec.v
`timescale 1ns/1ns
`default_nettype none
`include "atf_defines.vh"

// Overview of operation
// - numP counts buffers, capped at max burst on transmit; a received numP above it is flagged, not capped
// - seq num names next expected packet
// - pf reserved in superspeed mode
// - superspeedplus pf only when notification follows
// - stream pipe carries stream id 1..65535
// - zero stream id on stream pipe invalid
// - non-stream pipes treat stream id reserved
// - stream id sent zero without streams
// - ssi and wpa treated as reserved; received ssi and wpa are decoded when legacy smart iso is enabled
// - iso out: fields valid only ssi, no lpf
// - after lpf, ignore ssi, await ping
// - ssi hints link may enter low power
module atf_ack_codec #(
  parameter NUMP_W = 5,
  parameter SID_W = 16
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // receive side: ack packet dwords from the link layer
  input wire rx_valid,
  input wire [31:0] rx_dw1,
  input wire [31:0] rx_dw2,
  input wire rx_lpf,
  // transmit side: request to build an ack packet
  input wire tx_req,
  input wire [NUMP_W-1:0] tx_nump,
  input wire [4:0] tx_seq,
  input wire [SID_W-1:0] tx_sid,
  input wire notify_next,
  output reg tx_valid_q,
  output reg [31:0] tx_dw1_q,
  output reg [31:0] tx_dw2_q,
  // iso in power events
  input wire dp_lpf_sent,
  input wire ping_rx,
  // decoded receive fields
  output reg rx_done_q,
  output reg rx_invalid_q,
  output reg [NUMP_W-1:0] rx_nump_q,
  output reg [4:0] rx_seq_q,
  output reg rx_pf_q,
  output reg [SID_W-1:0] rx_sid_q,
  output reg rx_wpa_q,
  output reg rx_smart_valid_q,
  // link power hints
  output reg wait_ping_q,
  output reg lp_hint_q
);
  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  reg [12:0] ctrl_q; // mode and endpoint context
  wire ssp_mode = ctrl_q[`ATF_CTRL_SSP]; // superspeedplus operation
  wire streams_en = ctrl_q[`ATF_CTRL_STREAMS]; // bulk endpoint with streams
  wire smart_en = ctrl_q[`ATF_CTRL_SMART]; // legacy smart iso decode
  wire ep_iso = ctrl_q[`ATF_CTRL_ISO]; // isochronous endpoint
  wire ep_in = ctrl_q[`ATF_CTRL_DIRIN]; // in direction
  wire [4:0] max_burst = ctrl_q[`ATF_CTRL_BURST_MSB:`ATF_CTRL_BURST_LSB];
  wire iso_out = ep_iso & ~ep_in; // iso out endpoint
  wire iso_in = ep_iso & ep_in; // iso in endpoint

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire acc = psel & penable; // access phase, zero wait states
  wire wr = acc & pwrite; // write strobe
  wire hit_ctrl = (paddr == `ATF_REG_CTRL);
  wire hit_st = (paddr == `ATF_REG_STATUS);
  wire hit_rxf = (paddr == `ATF_REG_RXF);
  wire hit_rxs = (paddr == `ATF_REG_RXS);
  wire hit_txf = (paddr == `ATF_REG_TXF);
  wire mapped = hit_ctrl | hit_st | hit_rxf | hit_rxs | hit_txf;

  assign pready = 1'b1; // every access completes in its first access cycle
  assign pslverr = acc & ~mapped; // unmapped offsets answer with an error

  // control register write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `ATF_CTRL_RST;
    end else if (wr && hit_ctrl) begin
      ctrl_q <= pwdata[12:0];
    end
  end

  // ---------------------------------------------------------------
  // receive decode
  // ---------------------------------------------------------------
  wire [4:0] dec_nump; // numP field
  wire [4:0] dec_seq; // seq num field
  wire dec_pf; // pf after mode masking
  wire [15:0] dec_sid; // stream id after pipe masking
  wire dec_ssi; // ssi after legacy masking
  wire dec_wpa; // wpa after legacy masking
  wire dec_invalid; // zero stream id on stream pipe
  wire dec_over; // numP above burst size
  wire dec_smart; // smart iso fields meaningful

  // on iso out the decoder drops the smart iso fields when ssi comes beside lpf
  atf_rx_decode u_dec (
    .dw1(rx_dw1),
    .dw2(rx_dw2),
    .ssp_mode(ssp_mode),
    .stream_pipe(streams_en),
    .smart_iso_en(smart_en),
    .iso_out(iso_out),
    .lpf(rx_lpf),
    .max_burst(max_burst),
    .nump(dec_nump),
    .seq_num(dec_seq),
    .pf(dec_pf),
    .stream_id(dec_sid),
    .ssi(dec_ssi),
    .wpa(dec_wpa),
    .invalid(dec_invalid),
    .nump_over(dec_over),
    .smart_valid(dec_smart)
  );

  // wait for ping after lpf drops ssi from consideration on iso in
  wire ssi_heard = dec_ssi & ~(iso_in & wait_ping_q);

  // capture decoded fields, one-cycle done pulse per packet
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_done_q <= 1'b0;
      rx_invalid_q <= 1'b0;
      rx_nump_q <= {NUMP_W{1'b0}};
      rx_seq_q <= 5'h00;
      rx_pf_q <= 1'b0;
      rx_sid_q <= {SID_W{1'b0}};
      rx_wpa_q <= 1'b0;
      rx_smart_valid_q <= 1'b0;
    end else begin
      rx_done_q <= rx_valid;
      if (rx_valid) begin
        rx_invalid_q <= dec_invalid;
        rx_nump_q <= dec_nump[NUMP_W-1:0];
        rx_seq_q <= dec_seq;
        rx_pf_q <= dec_pf;
        rx_sid_q <= dec_sid[SID_W-1:0];
        // wpa only counts where the smart iso fields are valid
        rx_wpa_q <= dec_wpa & dec_smart & ssi_heard;
        rx_smart_valid_q <= dec_smart & ssi_heard;
      end
    end
  end

  // ---------------------------------------------------------------
  // iso power handling
  // ---------------------------------------------------------------
  // wait-for-ping: set when an iso in data packet with lpf leaves,
  // cleared by the host's ping; a set in the same cycle wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_ping_q <= 1'b0;
    end else if (iso_in && dp_lpf_sent) begin
      wait_ping_q <= 1'b1;
    end else if (ping_rx) begin
      wait_ping_q <= 1'b0;
    end
  end

  // low power hint follows the most recent ssi seen on an iso endpoint;
  // it is only a hint, the link manager decides whether to act on it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_hint_q <= 1'b0;
    end else if (!ep_iso) begin
      lp_hint_q <= 1'b0;
    end else if (rx_valid && !(iso_in && wait_ping_q)) begin
      lp_hint_q <= dec_ssi;
    end
  end

  // ---------------------------------------------------------------
  // transmit builder
  // ---------------------------------------------------------------
  wire [4:0] req_nump = tx_nump[4:0]; // requested buffer count
  // never advertise more buffers than the burst size allows
  wire [4:0] cap_nump = (req_nump > max_burst) ? max_burst : req_nump;
  // pf only in superspeedplus and only with a notification queued
  wire tx_pf = ssp_mode & notify_next;
  // stream id forced to zero when the endpoint has no streams
  wire [15:0] tx_sid_eff = streams_en ? tx_sid[15:0] : 16'h0000;
  // a zero id on a stream pipe would be rejected by the host
  wire tx_sid_bad = tx_req & streams_en & (tx_sid[15:0] == 16'h0000);
  reg [31:0] dw1_d; // next dword 1
  reg [31:0] dw2_d; // next dword 2

  // assemble owned fields over an all-zero word
  always @* begin
    dw1_d = 32'h00000000;
    dw2_d = 32'h00000000;
    dw1_d[`ATF_NUMP_MSB:`ATF_NUMP_LSB] = cap_nump;
    dw1_d[`ATF_SEQ_MSB:`ATF_SEQ_LSB] = tx_seq;
    dw1_d[`ATF_PF_BIT] = tx_pf;
    dw2_d[`ATF_SID_MSB:`ATF_SID_LSB] = tx_sid_eff;
    // ssi and wpa stay zero: deprecated, sent as reserved
    dw2_d[`ATF_SSI_BIT] = 1'b0;
    dw2_d[`ATF_WPA_BIT] = 1'b0;
  end

  // register the packet, one-cycle valid per request
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid_q <= 1'b0;
      tx_dw1_q <= 32'h00000000;
      tx_dw2_q <= 32'h00000000;
    end else begin
      tx_valid_q <= tx_req;
      if (tx_req) begin
        tx_dw1_q <= dw1_d & `ATF_DW1_MASK;
        tx_dw2_q <= dw2_d & `ATF_DW2_MASK;
      end
    end
  end

  // ---------------------------------------------------------------
  // sticky status flags
  // ---------------------------------------------------------------
  reg st_invalid_q; // an invalid packet was received
  reg st_over_q; // a received numP exceeded the burst size
  reg st_sid_err_q; // a transmit request had a zero stream id
  wire clr_st = wr & hit_st; // write-one-to-clear strobe
  wire set_inv = rx_valid & dec_invalid;
  wire set_over = rx_valid & dec_over;
  wire set_sid = tx_sid_bad;

  // set beats clear so an event in the clearing cycle is kept
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_invalid_q <= 1'b0;
      st_over_q <= 1'b0;
      st_sid_err_q <= 1'b0;
    end else begin
      st_invalid_q <= set_inv | (st_invalid_q & ~(clr_st & pwdata[`ATF_ST_INVALID]));
      st_over_q <= set_over | (st_over_q & ~(clr_st & pwdata[`ATF_ST_NUMP_OVER]));
      st_sid_err_q <= set_sid | (st_sid_err_q & ~(clr_st & pwdata[`ATF_ST_TX_SID_ERR]));
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  reg [31:0] rd_d; // selected read word

  // reserved bits read as zero, except control bits 7:5, which read back as written
  always @* begin
    rd_d = 32'h00000000;
    if (hit_ctrl) begin
      rd_d[12:0] = ctrl_q;
    end else if (hit_st) begin
      rd_d[`ATF_ST_INVALID] = st_invalid_q;
      rd_d[`ATF_ST_NUMP_OVER] = st_over_q;
      rd_d[`ATF_ST_TX_SID_ERR] = st_sid_err_q;
      rd_d[`ATF_ST_WAIT_PING] = wait_ping_q;
      rd_d[`ATF_ST_LP_HINT] = lp_hint_q;
      rd_d[`ATF_ST_SMART_VALID] = rx_smart_valid_q;
    end else if (hit_rxf) begin
      // last received fields at their packet positions
      rd_d[`ATF_NUMP_LSB+NUMP_W-1:`ATF_NUMP_LSB] = rx_nump_q;
      rd_d[`ATF_SEQ_MSB:`ATF_SEQ_LSB] = rx_seq_q;
      rd_d[`ATF_PF_BIT] = rx_pf_q;
    end else if (hit_rxs) begin
      rd_d[SID_W-1:0] = rx_sid_q;
      rd_d[`ATF_WPA_BIT] = rx_wpa_q;
    end else if (hit_txf) begin
      rd_d = tx_dw1_q;
    end else begin
      rd_d = 32'h00000000;
    end
  end

  // read data is combinational from registers, valid in the access cycle
  assign prdata = (acc && !pwrite) ? rd_d : 32'h00000000;
endmodule // atf_ack_codec
`default_nettype wire

// >>> sim/atf_ack_codec_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// port checker for the ack field codec
// ---------------------------------------------------------------
module atf_ack_codec_monitor #(
  parameter NUMP_W = 5,
  parameter SID_W = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb writes, for the control shadow
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // receive side
  input wire logic rx_valid,
  input wire logic [31:0] rx_dw1,
  input wire logic [31:0] rx_dw2,
  input wire logic rx_done_q,
  input wire logic rx_invalid_q,
  input wire logic [NUMP_W-1:0] rx_nump_q,
  input wire logic [4:0] rx_seq_q,
  input wire logic rx_pf_q,
  // transmit side
  input wire logic tx_req,
  input wire logic [NUMP_W-1:0] tx_nump,
  input wire logic [4:0] tx_seq,
  input wire logic [SID_W-1:0] tx_sid,
  input wire logic notify_next,
  input wire logic tx_valid_q,
  input wire logic [31:0] tx_dw1_q,
  input wire logic [31:0] tx_dw2_q,
  // power events
  input wire logic dp_lpf_sent,
  input wire logic ping_rx,
  input wire logic wait_ping_q
);
  // control shadow; pready is tied high so every access phase completes
  logic [12:0] ctl_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= 13'h0000;
    end else if (psel && penable && pwrite && paddr == 12'h000) begin
      ctl_q <= pwdata[12:0] & 13'h1f1f;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // iso in endpoint reports a data packet sent with lpf
  sequence s_lpf_in;
    dp_lpf_sent && ctl_q[3] && ctl_q[4];
  endsequence
  // the packet answer one cycle on, with its fields
  sequence s_rx_answer;
    rx_done_q && rx_nump_q == $past(rx_dw1[20:16]) && rx_seq_q == $past(rx_dw1[25:21]);
  endsequence
  a_rx_fields_taken: assert property (rx_valid |=> s_rx_answer)
    else $error("rx fields not captured");
  a_rx_pf_masked: assert property (rx_valid |=>
    rx_pf_q == ($past(rx_dw1[31]) && $past(ctl_q[0])))
    else $error("rx pf not masked");
  a_rx_zero_sid: assert property (rx_valid |=>
    rx_invalid_q == ($past(ctl_q[1]) && $past(rx_dw2[15:0]) == 16'h0000))
    else $error("rx invalid flag wrong");
  a_tx_answer: assert property (tx_req |=> tx_valid_q)
    else $error("tx request not answered");
  a_tx_seq_nump: assert property (tx_req |=> tx_dw1_q[25:16] == {$past(tx_seq),
    ($past(tx_nump) > $past(ctl_q[12:8])) ? $past(ctl_q[12:8]) : $past(tx_nump)})
    else $error("tx seq or nump wrong");
  a_tx_pf_gate: assert property (tx_req |=>
    tx_dw1_q[31] == ($past(notify_next) && $past(ctl_q[0])))
    else $error("tx pf wrong");
  a_tx_sid_zero: assert property (tx_req |=>
    tx_dw2_q[15:0] == ($past(ctl_q[1]) ? $past(tx_sid) : 16'h0000))
    else $error("tx stream id wrong");
  a_tx_reserved_zero: assert property (tx_valid_q |->
    (tx_dw1_q & 32'h7c00ffff) == 32'h0 && (tx_dw2_q & 32'hffff0000) == 32'h0)
    else $error("tx reserved bits set");
  a_ping_wait_set: assert property (s_lpf_in |=> wait_ping_q)
    else $error("wait for ping not set");
  a_ping_wait_clear: assert property (ping_rx && !dp_lpf_sent |=> !wait_ping_q)
    else $error("wait for ping not cleared");
endmodule // atf_ack_codec_monitor

bind atf_ack_codec atf_ack_codec_monitor #(.NUMP_W(NUMP_W), .SID_W(SID_W)) i_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .rx_valid(rx_valid), .rx_dw1(rx_dw1), .rx_dw2(rx_dw2),
  .rx_done_q(rx_done_q), .rx_invalid_q(rx_invalid_q), .rx_nump_q(rx_nump_q),
  .rx_seq_q(rx_seq_q), .rx_pf_q(rx_pf_q), .tx_req(tx_req), .tx_nump(tx_nump),
  .tx_seq(tx_seq), .tx_sid(tx_sid), .notify_next(notify_next), .tx_valid_q(tx_valid_q),
  .tx_dw1_q(tx_dw1_q), .tx_dw2_q(tx_dw2_q), .dp_lpf_sent(dp_lpf_sent),
  .ping_rx(ping_rx), .wait_ping_q(wait_ping_q));
`default_nettype wire

// >>> sim/atf_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// host side: ack dwords and ping events toward the device
// ---------------------------------------------------------------
module atf_host_model (
  // clock
  input wire logic pclk,
  // packet lines
  output logic rx_valid,
  output logic [31:0] rx_dw1,
  output logic [31:0] rx_dw2,
  output logic rx_lpf,
  // ping event
  output logic ping_rx
);
  initial begin
    rx_valid = 1'b0;
    rx_dw1 = 32'h0;
    rx_dw2 = 32'h0;
    rx_lpf = 1'b0;
    ping_rx = 1'b0;
  end
  // one packet for one cycle; bad lets a scenario send ssi beside lpf
  task automatic send(input logic [31:0] d1, input logic [31:0] d2, input logic lpf,
    input logic bad);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_dw1 <= d1;
    rx_dw2 <= (lpf && !bad) ? (d2 & 32'hfeffffff) : d2;
    rx_lpf <= lpf;
    @(posedge pclk);
    rx_valid <= 1'b0;
    // unqualified lines show the inverse so a stale value never matches
    rx_dw1 <= ~d1;
    rx_dw2 <= ~d2;
    rx_lpf <= ~lpf;
  endtask
  // ping pulse of one cycle
  task automatic ping();
    @(posedge pclk);
    ping_rx <= 1'b1;
    @(posedge pclk);
    ping_rx <= 1'b0;
  endtask
endmodule // atf_host_model
`default_nettype wire

// >>> sim/test_ack_tp_field_codec.sv
`timescale 1ns/1ns
`default_nettype none
module test_ack_tp_field_codec;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic tx_req = 1'b0, notify_next = 1'b0, dp_lpf_sent = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, c, d1, d2, r, e1;
  logic [4:0] tx_nump = 5'h00, tx_seq = 5'h00, mb, n;
  logic [15:0] tx_sid = 16'h0000;
  logic e, ss, st, sv, lp, lpf, txe;
  wire [31:0] prdata, rx_dw1, rx_dw2, tx_dw1_q, tx_dw2_q;
  wire pready, pslverr, rx_valid, rx_lpf, ping_rx, tx_valid_q, rx_done_q, rx_invalid_q;
  wire rx_pf_q, rx_wpa_q, rx_smart_valid_q, wait_ping_q, lp_hint_q;
  wire [4:0] rx_nump_q, rx_seq_q;
  wire [15:0] rx_sid_q;
  integer err_count = 0, samples_checked = 0, seed = 90772, i;
  // ---------------------------------------------------------------
  // design, host and clock
  // ---------------------------------------------------------------
  atf_ack_codec i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_dw1(rx_dw1), .rx_dw2(rx_dw2),
    .rx_lpf(rx_lpf), .tx_req(tx_req), .tx_nump(tx_nump), .tx_seq(tx_seq), .tx_sid(tx_sid),
    .notify_next(notify_next), .tx_valid_q(tx_valid_q), .tx_dw1_q(tx_dw1_q),
    .tx_dw2_q(tx_dw2_q), .dp_lpf_sent(dp_lpf_sent), .ping_rx(ping_rx),
    .rx_done_q(rx_done_q), .rx_invalid_q(rx_invalid_q), .rx_nump_q(rx_nump_q),
    .rx_seq_q(rx_seq_q), .rx_pf_q(rx_pf_q), .rx_sid_q(rx_sid_q), .rx_wpa_q(rx_wpa_q),
    .rx_smart_valid_q(rx_smart_valid_q), .wait_ping_q(wait_ping_q), .lp_hint_q(lp_hint_q));
  atf_host_model i_host (.pclk(pclk), .rx_valid(rx_valid), .rx_dw1(rx_dw1),
    .rx_dw2(rx_dw2), .rx_lpf(rx_lpf), .ping_rx(ping_rx));
  initial begin
    forever #4 pclk = ~pclk;
  end
  // ---------------------------------------------------------------
  // compare, bus cycle, verdict
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // apb master: holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge pclk);
    err_count = err_count + 1;
    results();
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h004, 0);
    chk(r, 0);
    apb(0, 12'h020, 0);
    chk({r[30:0], e}, 1);
    $display("reset and unmapped test done");
    // random control words; stream id zero on every fourth pass
    for (i = 0; i < 24; i = i + 1) begin
      c = $random(seed) & 32'h1f1f;
      {mb, ss, st} = {c[12:8], c[0], c[1]};
      apb(1, 12'h000, c);
      apb(0, 12'h000, 0);
      chk(r, c);
      n = $random(seed);
      d1 = $random(seed);
      d2 = (i % 4 == 0) ? 32'h0 : $random(seed) & 32'hffff;
      @(posedge pclk);
      tx_req <= 1'b1;
      tx_nump <= n;
      tx_seq <= d1[4:0];
      tx_sid <= d2[15:0];
      notify_next <= d1[5];
      @(posedge pclk);
      tx_req <= 1'b0;
      @(negedge pclk);
      e1 = {ss & d1[5], 5'h00, d1[4:0], (n > mb) ? mb : n, 16'h0000};
      chk(tx_dw1_q, e1);
      chk(tx_dw2_q, st ? d2 : 0);
      chk(tx_valid_q, 1);
      apb(0, 12'h010, 0);
      chk(r, e1);
      txe = st && d2 == 0;
      // receive with junk in the reserved gaps
      d1 = $random(seed);
      d2 = d2 | ($random(seed) & 32'h03ff0000);
      lpf = $random(seed);
      // an iso in host never marks lpf
      if (c[3] && c[4]) lpf = 1'b0;
      i_host.send(d1, d2, lpf, i[0]);
      if (lpf && !i[0]) d2[24] = 1'b0;
      @(negedge pclk);
      sv = c[3] & ~c[4] & c[2] & d2[24] & ~lpf;
      lp = c[3] & c[2] & d2[24];
      chk(rx_sid_q, st ? d2[15:0] : 0);
      chk(rx_invalid_q, st && d2[15:0] == 0);
      chk({rx_wpa_q, rx_smart_valid_q}, {d2[25] & sv, sv});
      chk(lp_hint_q, lp);
      chk(rx_done_q, 1);
      chk({rx_pf_q, rx_seq_q, rx_nump_q}, {d1[31] & ss, d1[25:16]});
      apb(0, 12'h00c, 0);
      chk(r, {6'h00, d2[25] & sv, 9'h000, st ? d2[15:0] : 16'h0000});
      apb(0, 12'h008, 0);
      chk(r, {d1[31] & ss, 5'h00, d1[25:16], 16'h0000});
      apb(0, 12'h004, 0);
      chk(r, {sv, lp, 1'b0, txe, d1[20:16] > mb, st && d2[15:0] == 0});
      apb(1, 12'h004, 32'h7);
      apb(0, 12'h004, 0);
      chk(r[2:0], 0);
    end
    $display("field test done");
    // iso in: lpf data packet, then wait for the host ping
    apb(1, 12'h000, 32'h1c);
    i_host.send(32'h0, 32'h01000001, 1'b0, 1'b0);
    @(negedge pclk);
    chk({lp_hint_q, rx_smart_valid_q}, 2);
    @(posedge pclk);
    dp_lpf_sent <= 1'b1;
    @(posedge pclk);
    dp_lpf_sent <= 1'b0;
    i_host.send(32'h0, 32'h00000001, 1'b0, 1'b0);
    @(negedge pclk);
    chk({wait_ping_q, lp_hint_q}, 3);
    i_host.ping();
    @(negedge pclk);
    chk(wait_ping_q, 0);
    $display("power test done");
    results();
  end
endmodule // test_ack_tp_field_codec
`default_nettype wire
